// File: hdl/gpcd_port_regs.v
// Port C and port D register block: direction and pin-level registers for both ports, output value register for port D only
//
// How it works
// - Data offset answers; IO address is offset-0x20
// - Addresses 0x60 up unreachable via IO
// - Each direction bit picks pin direction
// - Pin-level register write toggles pins
// - Direction and output registers reset 0x00
// - Pin-level registers have no reset value
// - Virtual-port direction access hits real register
`timescale 1ns/1ps
`default_nettype none
`include "gpcd_regs.vh"

module gpcd_port_regs #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             CLOCK_I,
  input  wire             SYS_RST_I,
  // Data-space access (load/store)
  input  wire [7:0]       DS_ADDR_I,
  input  wire             DS_RD_I,
  input  wire             DS_WR_I,
  // Short IO-instruction access
  input  wire [5:0]       IO_ADDR_I,
  input  wire             IO_RD_I,
  input  wire             IO_WR_I,
  // Virtual-port direction access
  input  wire             VP_C_DIR_RD_I,
  input  wire             VP_C_DIR_WR_I,
  input  wire             VP_D_DIR_RD_I,
  input  wire             VP_D_DIR_WR_I,
  // Write data and read answer
  input  wire [WIDTH-1:0] WDATA_I,
  output reg  [WIDTH-1:0] RDATA_O,
  output reg              RVALID_O,
  // Port C pins
  input  wire [WIDTH-1:0] PORT_C_PIN_I,
  output wire [WIDTH-1:0] PORT_C_OE_O,
  output reg  [WIDTH-1:0] PORT_C_TOGGLE_O,
  // Port D pins
  input  wire [WIDTH-1:0] PORT_D_PIN_I,
  output wire [WIDTH-1:0] PORT_D_OUT_O,
  output wire [WIDTH-1:0] PORT_D_OE_O
);

  // ****************************************
  // Address decode
  // ****************************************
  reg  [WIDTH-1:0] port_c_direction;
  reg  [WIDTH-1:0] port_d_direction;
  reg  [WIDTH-1:0] port_d_output_value;
  wire [WIDTH-1:0] port_c_pin_levels;
  wire [WIDTH-1:0] port_d_pin_levels;
  wire [7:0]       io_as_ds;
  wire [7:0]       addr;
  wire             rd;
  wire             wr;
  wire             ds_hit;

  // six IO bits stop below 0x60
  assign io_as_ds = {2'b00, IO_ADDR_I} + `GPCD_IO_SPACE_BASE;
  assign ds_hit   = DS_RD_I | DS_WR_I;
  // DS strobes win the decode if both buses fire
  assign addr     = ds_hit ? DS_ADDR_I : io_as_ds;
  assign rd       = DS_RD_I | IO_RD_I;
  assign wr       = DS_WR_I | IO_WR_I;

  // Unmapped writes change nothing
  wire wr_c_pin = wr & (addr == `GPCD_PORT_C_PIN_LEVELS_OFS);
  wire wr_c_dir = wr & (addr == `GPCD_PORT_C_DIRECTION_OFS);
  wire wr_d_pin = wr & (addr == `GPCD_PORT_D_PIN_LEVELS_OFS);
  wire wr_d_dir = wr & (addr == `GPCD_PORT_D_DIRECTION_OFS);
  wire wr_d_out = wr & (addr == `GPCD_PORT_D_OUTPUT_VALUE_OFS);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // pin levels follow the pins, no reset
  // Reads lag a pin change by two clocks
  gpcd_sync #(
    .WIDTH (WIDTH)
  ) u_sync_c (
    .clk_i   (CLOCK_I),
    .async_i (PORT_C_PIN_I),
    .sync_o  (port_c_pin_levels)
  );

  gpcd_sync #(
    .WIDTH (WIDTH)
  ) u_sync_d (
    .clk_i   (CLOCK_I),
    .async_i (PORT_D_PIN_I),
    .sync_o  (port_d_pin_levels)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  reg  [WIDTH-1:0] next_port_c_direction;
  reg  [WIDTH-1:0] next_port_d_direction;
  reg  [WIDTH-1:0] next_port_d_output_value;
  reg  [WIDTH-1:0] next_port_c_toggle;
  reg  [WIDTH-1:0] bus_rdata;
  reg  [WIDTH-1:0] next_rdata;
  wire [WIDTH-1:0] port_d_toggled;
  wire             next_rvalid;

  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < WIDTH; bit_idx = bit_idx + 1) begin : g_toggle
      assign port_d_toggled[bit_idx] = port_d_output_value[bit_idx] ^ WDATA_I[bit_idx];
    end
  endgenerate

  always @* begin
    next_port_c_direction = port_c_direction;
    if (wr_c_dir | VP_C_DIR_WR_I) begin
      next_port_c_direction = WDATA_I;
    end
  end

  always @* begin
    next_port_d_direction = port_d_direction;
    if (wr_d_dir | VP_D_DIR_WR_I) begin
      next_port_d_direction = WDATA_I;
    end
  end

  // pin write toggles, output write stores
  always @* begin
    next_port_d_output_value = port_d_output_value;
    if (wr_d_pin) begin
      next_port_d_output_value = port_d_toggled;
    end else if (wr_d_out) begin
      next_port_d_output_value = WDATA_I;
    end
  end

  // port C toggle pulse to its output latch
  always @* begin
    next_port_c_toggle = {WIDTH{1'b0}};
    if (wr_c_pin) begin
      next_port_c_toggle = WDATA_I;
    end
  end

  // Bus read select; unmapped offsets answer zero
  always @* begin
    case (addr)
      `GPCD_PORT_C_PIN_LEVELS_OFS:   bus_rdata = port_c_pin_levels;
      `GPCD_PORT_C_DIRECTION_OFS:    bus_rdata = port_c_direction;
      `GPCD_PORT_D_PIN_LEVELS_OFS:   bus_rdata = port_d_pin_levels;
      `GPCD_PORT_D_DIRECTION_OFS:    bus_rdata = port_d_direction;
      `GPCD_PORT_D_OUTPUT_VALUE_OFS: bus_rdata = port_d_output_value;
      default:                       bus_rdata = {WIDTH{1'b0}};
    endcase
  end

  // Virtual direction reads beat bus reads
  always @* begin
    next_rdata = {WIDTH{1'b0}};
    if (VP_C_DIR_RD_I) begin
      next_rdata = port_c_direction;
    end else if (VP_D_DIR_RD_I) begin
      next_rdata = port_d_direction;
    end else if (rd) begin
      next_rdata = bus_rdata;
    end
  end

  // Every read strobe raises the answer flag
  assign next_rvalid = rd | VP_C_DIR_RD_I | VP_D_DIR_RD_I;

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      port_c_direction    <= `GPCD_DIRECTION_RST;
      port_d_direction    <= `GPCD_DIRECTION_RST;
      port_d_output_value <= `GPCD_OUTPUT_VALUE_RST;
      PORT_C_TOGGLE_O     <= {WIDTH{1'b0}};
    end else begin
      port_c_direction    <= next_port_c_direction;
      port_d_direction    <= next_port_d_direction;
      port_d_output_value <= next_port_d_output_value;
      PORT_C_TOGGLE_O     <= next_port_c_toggle;
    end
  end

  assign PORT_C_OE_O  = port_c_direction;
  assign PORT_D_OE_O  = port_d_direction;
  assign PORT_D_OUT_O = port_d_output_value;

  // ****************************************
  // Read answer
  // ****************************************
  // Answer stands for one cycle only
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      RDATA_O  <= {WIDTH{1'b0}};
      RVALID_O <= 1'b0;
    end else begin
      RDATA_O  <= next_rdata;
      RVALID_O <= next_rvalid;
    end
  end

endmodule // gpcd_port_regs

`default_nettype wire

// File: hdl/gpcd_regs.vh
// Register map, reset values and address constants for the port C/D register block
`ifndef GPCD_REGS_VH
`define GPCD_REGS_VH

// ****************************************
// Data-space offsets
// ****************************************
`define GPCD_PORT_C_PIN_LEVELS_OFS    8'h26
`define GPCD_PORT_C_DIRECTION_OFS     8'h27
`define GPCD_PORT_D_PIN_LEVELS_OFS    8'h29
`define GPCD_PORT_D_DIRECTION_OFS     8'h2a
`define GPCD_PORT_D_OUTPUT_VALUE_OFS  8'h2b

// ****************************************
// Address space limits
// ****************************************
`define GPCD_IO_SPACE_BASE            8'h20
`define GPCD_IO_SPACE_LAST            8'h3f
`define GPCD_EXT_SPACE_BASE           8'h60

// ****************************************
// Reset values
// ****************************************
`define GPCD_DIRECTION_RST            8'h00
`define GPCD_OUTPUT_VALUE_RST         8'h00

`endif

// File: hdl/gpcd_sync.v
// Two-stage synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none

module gpcd_sync #(
  parameter WIDTH = 8
) (
  // Clock
  input  wire             clk_i,
  // Asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always @(posedge clk_i) begin
    stage1 <= async_i;
    sync_o <= stage1;
  end

endmodule // gpcd_sync

`default_nettype wire

// File: tb/gpcd_chk_sva.sv
// Port assertions for the port C/D register block
`timescale 1ns/1ps
`default_nettype none
module gpcd_chk (
  input wire logic       CLOCK_I, SYS_RST_I, DS_RD_I, DS_WR_I, IO_RD_I, IO_WR_I,
  input wire logic       VP_C_DIR_WR_I, RVALID_O,
  input wire logic [5:0] IO_ADDR_I,
  input wire logic [7:0] DS_ADDR_I, WDATA_I, PORT_C_OE_O, PORT_C_TOGGLE_O, PORT_D_OUT_O,
  input wire logic [7:0] PORT_D_OE_O);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  wire io = IO_WR_I & ~DS_WR_I & ~DS_RD_I;
  property p_rv; DS_RD_I | IO_RD_I |=> RVALID_O; endproperty
  a_rv: assert property (p_rv) else $error("no answer");
  property p_io; io && IO_ADDR_I == 6'h0b |=> PORT_D_OUT_O == $past(WDATA_I); endproperty
  a_io: assert property (p_io) else $error("io write");
  property p_ds; DS_WR_I && DS_ADDR_I == 8'h2a |=> PORT_D_OE_O == $past(WDATA_I); endproperty
  a_ds: assert property (p_ds) else $error("ds write");
  property p_hd; !(DS_WR_I | IO_WR_I | VP_C_DIR_WR_I) |=> $stable(PORT_C_OE_O); endproperty
  a_hd: assert property (p_hd) else $error("drift");
  property p_td; io && IO_ADDR_I == 6'h09 |=>
    (PORT_D_OUT_O ^ $past(PORT_D_OUT_O)) == $past(WDATA_I); endproperty
  a_td: assert property (p_td) else $error("d toggle");
  property p_tc; DS_WR_I && DS_ADDR_I == 8'h26 |=> PORT_C_TOGGLE_O == $past(WDATA_I); endproperty
  a_tc: assert property (p_tc) else $error("c toggle");
  property p_rs; disable iff (1'b0) SYS_RST_I |=>
    !(PORT_D_OE_O | PORT_D_OUT_O | PORT_C_OE_O); endproperty
  a_rs: assert property (p_rs) else $error("reset");
  property p_vp; VP_C_DIR_WR_I |=> PORT_C_OE_O == $past(WDATA_I); endproperty
  a_vp: assert property (p_vp) else $error("virtual");
  c_td: cover property (io && IO_ADDR_I == 6'h09);
  c_vp: cover property (VP_C_DIR_WR_I);
  c_rd: cover property (RVALID_O);
endmodule // gpcd_chk
bind gpcd_port_regs gpcd_chk chk (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .DS_RD_I(DS_RD_I),
  .DS_WR_I(DS_WR_I), .IO_RD_I(IO_RD_I), .IO_WR_I(IO_WR_I), .VP_C_DIR_WR_I(VP_C_DIR_WR_I),
  .RVALID_O(RVALID_O), .IO_ADDR_I(IO_ADDR_I), .DS_ADDR_I(DS_ADDR_I), .WDATA_I(WDATA_I),
  .PORT_C_OE_O(PORT_C_OE_O), .PORT_C_TOGGLE_O(PORT_C_TOGGLE_O), .PORT_D_OUT_O(PORT_D_OUT_O),
  .PORT_D_OE_O(PORT_D_OE_O));
`default_nettype wire

// File: tb/gpcd_pins.sv
// Pin model: a driven pin shows the block's level, an input pin the outside level
`timescale 1ns/1ps
`default_nettype none
module gpcd_pins (input wire logic [7:0] oe_i, out_i, ext_i, output wire logic [7:0] pin_o);
  assign pin_o = oe_i & out_i | ~oe_i & ext_i;
endmodule // gpcd_pins
`default_nettype wire

// File: tb/gpcd_port_regs_tb_top.sv
// Bench: register calls with expected answers
`timescale 1ns/1ps
`default_nettype none
module gpcd_port_regs_tb_top;
  reg     clk = 0, rst = 1;
  reg     [7:0] s = 0, a = 0, w = 0, pc = 0;
  wire    [7:0] r, coe, ctg, dout, doe, pd;
  wire          rv;
  integer n_mismatch = 0, n_tests = 0, cyc = 0;
  gpcd_port_regs uut (.CLOCK_I(clk), .SYS_RST_I(rst), .DS_ADDR_I(a), .DS_WR_I(s[0]),
    .DS_RD_I(s[1]), .IO_ADDR_I(a[5:0]), .IO_WR_I(s[2]), .IO_RD_I(s[3]), .VP_D_DIR_WR_I(s[4]),
    .VP_D_DIR_RD_I(s[5]), .VP_C_DIR_WR_I(s[6]), .VP_C_DIR_RD_I(s[7]), .WDATA_I(w),
    .RDATA_O(r), .RVALID_O(rv), .PORT_C_PIN_I(pc), .PORT_C_OE_O(coe), .PORT_C_TOGGLE_O(ctg),
    .PORT_D_PIN_I(pd), .PORT_D_OUT_O(dout), .PORT_D_OE_O(doe));
  gpcd_pins pins (.oe_i(doe), .out_i(dout), .ext_i(8'hc3), .pin_o(pd));
  always #10 clk = ~clk;
  always @(posedge clk) if (++cyc == 999) report_and_stop;
  task cmp(input [7:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: %h, want %h", $time, g, e);
    end
  endtask
  task acc(input [7:0] k, d, v);
    @(posedge clk);
    {s, a, w} <= {k, d, v};
    @(posedge clk);
    s <= 0;
    #1;
  endtask
  task rd(input [7:0] k, d, e);
    acc(k, d, 0);
    cmp(r, e);
    cmp({7'h00, rv}, 8'h01);
  endtask
  task report_and_stop;
    n_mismatch += cyc > 998;
    $display("%0d compares, %0d wrong", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    rd(8'h02, 8'h27, 8'h00);
    cmp(coe | doe | dout, 8'h00);
    acc(8'h01, 8'h2a, 8'h0f);
    cmp(doe, 8'h0f);
    acc(8'h04, 8'h0b, 8'h5a);
    rd(8'h02, 8'h2b, 8'h5a);
    rd(8'h08, 8'h0a, 8'h0f);
    acc(8'h01, 8'h6a, 8'hff);
    cmp(doe, 8'h0f);
    $display("test 1 end");
    acc(8'h04, 8'h09, 8'h0f);
    cmp(dout, 8'h55);
    acc(8'h01, 8'h26, 8'ha5);
    cmp(ctg, 8'ha5);
    @(posedge clk);
    pc <= 8'h3c;
    #1;
    cmp(ctg, 8'h00);
    repeat (3) @(posedge clk);
    rd(8'h08, 8'h06, 8'h3c);
    rd(8'h02, 8'h29, 8'hc5);
    $display("test 2 end");
    acc(8'h40, 0, 8'h81);
    cmp(coe, 8'h81);
    rd(8'h80, 0, 8'h81);
    rd(8'h20, 0, 8'h0f);
    acc(8'h10, 0, 8'h3c);
    cmp(doe, 8'h3c);
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    #1;
    cmp(coe | doe | dout, 8'h00);
    @(posedge clk);
    rst <= 0;
    rd(8'h08, 8'h07, 8'h00);
    $display("test 3 end");
    report_and_stop;
  end
endmodule // gpcd_port_regs_tb_top
`default_nettype wire
